// *** sap_device.sv ***
// Our own choices: strobed register access and the register offsets.
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
// Operation
// - pin mode: i2s only, 32/48/64 fs
// - register mode adds left and right justified
// - double speed only under register control
// - source supplies 32/48/64 fs bit clock
// - i2s: select low left, high right
// - i2s: data starts one bit after select
// - two's complement, msb first, rising capture
// - justified formats: select high left, low right
// - left justified: msb with select edge
// - left justified: 16-24 bits, trailing zeros
// - right justified 24-bit: msb eight bits late
// - right justified: lsb just before select edge
// - right justified: leading positions zero filled
// - dc filter at front, forced in pin mode
// - ctrl bit 7 bypasses the dc filter
// - output dc: power stage off, latched fault
module sap_device #(
  parameter int HPF_SHIFT = 10
) (
  input wire logic CLK,
  input wire logic RESET_N,
  sap_if.device LINK,
  input wire logic HW_MODE,
  input wire logic SHUTDOWN_N,
  input wire logic DC_DETECT,
  input wire logic [7:0] ADDR,
  input wire logic [7:0] WDATA,
  input wire logic WR,
  input wire logic RD,
  output logic [7:0] RDATA,
  output logic [23:0] LEFT,
  output logic [23:0] RIGHT,
  output logic SAMPLE_VALID,
  output logic IRQ,
  output logic POWER_STAGE_EN,
  output logic DC_OUTPUT_ERROR
);
  localparam int NP = 6;
  localparam int AW = 24 + HPF_SHIFT;

  logic [NP-1:0] s1, s2, s3, f;
  logic [7:0] ctrl;
  logic [4:0] wlen;
  logic [2:0] stat;
  logic [2:0] mask;
  logic fs_prev, sel_prev, started, have_left, go, fault;
  logic [31:0] sh;
  logic [5:0] cnt;
  logic [23:0] left_word;
  sap_pkg::sap_sample_t xin [2];
  logic signed [AW-1:0] acc [2];
  wire logic [23:0] yout [2];

  wire logic [NP-1:0] pins = {HW_MODE, SHUTDOWN_N, DC_DETECT, LINK.serial_data,
                              LINK.channel_frame_select, LINK.bit_clock};
  wire logic hw = f[5];
  wire logic sd_n = f[4];
  wire logic dc_in = f[3];
  // capture on the filtered rising edge of the bit clock
  wire logic bclk_rise = ~f[0] & s2[0] & s3[0];
  wire logic fs_in = s3[1];
  wire logic sdata_in = s3[2];

  // pin mode forces i2s; the spare code also falls back to i2s
  wire sap_pkg::sap_fmt_e ctrl_fmt = sap_pkg::sap_fmt_e'(ctrl[`SAP_CTRL_FMT_LSB +: 2]);
  wire sap_pkg::sap_fmt_e fmt = (hw || ctrl_fmt == sap_pkg::SAP_FMT_RSVD) ?
                                sap_pkg::SAP_FMT_I2S : ctrl_fmt;
  wire logic is_i2s = (fmt == sap_pkg::SAP_FMT_I2S);
  // double speed only under register control
  wire logic ds = ~hw & ctrl[`SAP_CTRL_DS_BIT];
  // bypass only possible under register control
  wire logic bypass = ~hw & ctrl[`SAP_CTRL_BYPASS_BIT];
  wire logic amp_req = sd_n & (hw | ctrl[`SAP_CTRL_PWR_BIT]);

  // i2s select delayed one bit, justified taken as is
  wire logic sel = is_i2s ? fs_prev : fs_in;
  wire logic boundary = bclk_rise && (sel != sel_prev);
  wire logic left_done = is_i2s ? ~sel_prev : sel_prev;
  wire logic [31:0] aligned = sh << (6'd32 - cnt);
  // trailing positions past the word length forced to zero
  wire logic [23:0] trail_mask = ~(24'hffffff >> wlen);
  // word from the last bits, leading zero
  wire logic [23:0] lead_mask = ~(24'hffffff << wlen);
  wire logic [23:0] word = (fmt == sap_pkg::SAP_FMT_RIGHT_JUST) ? (sh[23:0] & lead_mask) :
                           (fmt == sap_pkg::SAP_FMT_LEFT_JUST) ? (aligned[31:8] & trail_mask) :
                           aligned[31:8];
  // slots must be 16, 24 or 32 bits
  wire logic ratio_ok = (cnt == 6'd16) || (cnt == 6'd24) || (cnt == 6'd32);
  wire logic slot_end = boundary && started;
  wire logic pair_end = slot_end && !left_done && have_left;
  wire logic ratio_err = slot_end && !ratio_ok;
  wire logic dc_event = dc_in && amp_req && !fault;
  wire logic [2:0] events = {dc_event, ratio_err, go};

  wire logic wr_ctrl = WR && (ADDR == `SAP_CTRL_ADDR);
  wire logic wr_wlen = WR && (ADDR == `SAP_WLEN_ADDR);
  wire logic wr_stat = WR && (ADDR == `SAP_STAT_ADDR);
  wire logic wr_mask = WR && (ADDR == `SAP_MASK_ADDR);
  wire logic [7:0] state_view = {2'h0, fault, POWER_STAGE_EN, ds, bypass, hw, is_i2s};
  wire logic [7:0] rd_val = (ADDR == `SAP_CTRL_ADDR) ? ctrl :
                            (ADDR == `SAP_WLEN_ADDR) ? {3'h0, wlen} :
                            (ADDR == `SAP_STAT_ADDR) ? {5'h00, stat} :
                            (ADDR == `SAP_MASK_ADDR) ? {5'h00, mask} :
                            (ADDR == `SAP_STATE_ADDR) ? state_view : 8'h00;
  wire logic [4:0] wlen_in = (WDATA[4:0] < 5'd16) ? 5'd16 :
                             (WDATA[4:0] > 5'd24) ? 5'd24 : WDATA[4:0];

  // one-pole dc tracker per channel; corner follows the speed mode
  for (genvar c = 0; c < 2; c++) begin : g_hpf
    wire logic signed [AW-1:0] dcv = acc[c] >>> (ds ? HPF_SHIFT - 1 : HPF_SHIFT);
    wire logic signed [24:0] diff = 25'(xin[c]) - 25'(dcv);
    wire logic [23:0] sat = (diff[24] != diff[23]) ? {diff[24], {23{~diff[24]}}} : diff[23:0];
    // bypass passes the padded word untouched
    assign yout[c] = bypass ? xin[c] : sat;
    always_ff @(posedge CLK or negedge RESET_N) begin
      if (!RESET_N) begin
        acc[c] <= '0;
      end else if (go) begin
        acc[c] <= acc[c] + AW'(xin[c]) - dcv;
      end
    end
  end

  // first stage feeds only the second; decisions use the later two
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      s1 <= '0;
      s2 <= '0;
      s3 <= '0;
      f <= '0;
    end else begin
      s1 <= pins;
      s2 <= s1;
      s3 <= s2;
      f <= (~(s2 ^ s3) & s3) | ((s2 ^ s3) & f);
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fs_prev <= 1'b0;
      sel_prev <= 1'b0;
      sh <= 32'h00000000;
      cnt <= 6'h00;
      started <= 1'b0;
    end else if (bclk_rise) begin
      fs_prev <= fs_in;
      sel_prev <= sel;
      sh <= {sh[30:0], sdata_in};
      cnt <= boundary ? 6'h01 : ((cnt == 6'h3f) ? cnt : cnt + 6'h01);
      started <= started | boundary;
    end
  end

  // pair a left slot with the right one after it
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      left_word <= 24'h000000;
      have_left <= 1'b0;
      go <= 1'b0;
      xin[0] <= '0;
      xin[1] <= '0;
    end else begin
      go <= pair_end;
      if (slot_end && left_done) begin
        left_word <= word;
        have_left <= 1'b1;
      end else if (pair_end) begin
        xin[0] <= left_word;
        xin[1] <= word;
        have_left <= 1'b0;
      end
    end
  end

  // one strobe, data held until the next pair
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      LEFT <= 24'h000000;
      RIGHT <= 24'h000000;
      SAMPLE_VALID <= 1'b0;
    end else begin
      SAMPLE_VALID <= go;
      if (go) begin
        LEFT <= yout[0];
        RIGHT <= yout[1];
      end
    end
  end

  // latch until shutdown or, in register mode, a cleared power bit; power off while latched
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      fault <= 1'b0;
      POWER_STAGE_EN <= 1'b0;
    end else begin
      fault <= dc_event | (fault & amp_req);
      POWER_STAGE_EN <= amp_req & ~fault & ~dc_event;
    end
  end
  assign DC_OUTPUT_ERROR = fault;

  // status set wins over write-one-to-clear
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      ctrl <= `SAP_CTRL_RESET;
      wlen <= `SAP_WLEN_RESET;
      mask <= `SAP_MASK_RESET;
      stat <= 3'h0;
      RDATA <= 8'h00;
      IRQ <= 1'b0;
    end else begin
      if (wr_ctrl) begin
        ctrl <= WDATA;
      end
      if (wr_wlen) begin
        wlen <= wlen_in;
      end
      if (wr_mask) begin
        mask <= WDATA[2:0];
      end
      stat <= (stat & ~(wr_stat ? WDATA[2:0] : 3'h0)) | events;
      RDATA <= RD ? rd_val : 8'h00;
      IRQ <= |(stat & mask);
    end
  end
endmodule
`default_nettype wire

// *** sap_regs.svh ***
`ifndef SAP_REGS_SVH
`define SAP_REGS_SVH

`define SAP_CTRL_ADDR 8'h02
`define SAP_WLEN_ADDR 8'h03
`define SAP_STAT_ADDR 8'h04
`define SAP_MASK_ADDR 8'h05
`define SAP_STATE_ADDR 8'h06

`define SAP_CTRL_FMT_LSB 0
`define SAP_CTRL_DS_BIT 2
`define SAP_CTRL_PWR_BIT 3
`define SAP_CTRL_BYPASS_BIT 7

`define SAP_STAT_PAIR_BIT 0
`define SAP_STAT_RATIO_BIT 1
`define SAP_STAT_DC_BIT 2

`define SAP_CTRL_RESET 8'h00
`define SAP_WLEN_RESET 5'h18
`define SAP_MASK_RESET 3'h0

`define SAP_BCLK_HALF_DIV 8'h04

`endif

// *** sap_pkg.sv ***
package sap_pkg;
  typedef enum logic [1:0] {
    SAP_FMT_I2S,
    SAP_FMT_LEFT_JUST,
    SAP_FMT_RIGHT_JUST,
    SAP_FMT_RSVD
  } sap_fmt_e;
  typedef logic signed [23:0] sap_sample_t;
endpackage

// *** sap_if.sv ***
`timescale 1ns/1ns
`default_nettype none
interface sap_if;
  logic bit_clock;
  logic channel_frame_select;
  logic serial_data;
  modport source (
    output bit_clock,
    output channel_frame_select,
    output serial_data
  );
  modport device (
    input bit_clock,
    input channel_frame_select,
    input serial_data
  );
endinterface
`default_nettype wire

// *** sap_source.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
module sap_source #(
  parameter logic [7:0] DIV_HALF = `SAP_BCLK_HALF_DIV
) (
  input wire logic CLK,
  input wire logic RESET_N,
  sap_if.source LINK,
  input wire logic ENABLE,
  input wire logic [1:0] FORMAT,
  input wire logic [5:0] SLOT_BITS,
  input wire logic [4:0] WORD_LEN,
  input wire logic [23:0] LEFT_IN,
  input wire logic [23:0] RIGHT_IN,
  output logic SAMPLE_TAKEN
);
  logic [7:0] div;
  logic bclk;
  logic [6:0] d;
  logic [23:0] left_cur;
  logic [23:0] right_cur;
  logic fs;
  logic sd;

  wire logic is_i2s = (FORMAT == 2'(sap_pkg::SAP_FMT_I2S)) || (FORMAT == 2'(sap_pkg::SAP_FMT_RSVD));
  wire logic is_rjust = (FORMAT == 2'(sap_pkg::SAP_FMT_RIGHT_JUST));
  wire logic [6:0] frame = {SLOT_BITS, 1'b0};
  wire logic toggle = ENABLE && (div == DIV_HALF - 8'h01);
  // data moves on the falling edge so the device sees it stable at the rise
  wire logic fall = toggle && bclk;
  wire logic [6:0] d_inc = d + 7'h01;
  wire logic [6:0] next_d = (d_inc >= frame) ? 7'h00 : d_inc;
  wire logic new_frame = (next_d == 7'h00);
  // select leads the data by one bit in i2s
  wire logic [6:0] fs_inc = next_d + 7'h01;
  wire logic [6:0] fs_pos = is_i2s ? ((fs_inc >= frame) ? 7'h00 : fs_inc) : next_d;
  wire logic fs_ch = (fs_pos >= {1'b0, SLOT_BITS});
  // left low in i2s, high in the justified formats
  wire logic next_fs = is_i2s ? fs_ch : ~fs_ch;
  wire logic d_ch = (next_d >= {1'b0, SLOT_BITS});
  wire logic [5:0] j = 6'(next_d - (d_ch ? {1'b0, SLOT_BITS} : 7'h00));
  wire logic [23:0] word = new_frame ? LEFT_IN : (d_ch ? right_cur : left_cur);
  wire logic [5:0] rjust_start = SLOT_BITS - {1'b0, WORD_LEN};
  wire logic [5:0] rjust_j = j - rjust_start;
  wire logic [4:0] ljust_idx = 5'(6'h17 - j);
  wire logic [4:0] rjust_idx = 5'(6'h17 - rjust_j);
  // msb first, msb at the slot start
  wire logic ljust_bit = (j < {1'b0, WORD_LEN}) && word[ljust_idx];
  // word ends on the last bit of the slot
  wire logic rjust_bit = (j >= rjust_start) && word[rjust_idx];
  wire logic next_sd = is_rjust ? rjust_bit : ljust_bit;

  assign LINK.bit_clock = bclk;
  assign LINK.channel_frame_select = fs;
  assign LINK.serial_data = sd;

  // bit clock from a divider, slot of 16, 24 or 32 bits
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      div <= 8'h00;
      bclk <= 1'b0;
    end else if (toggle) begin
      div <= 8'h00;
      bclk <= ~bclk;
    end else if (ENABLE) begin
      div <= div + 8'h01;
    end
  end

  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      d <= 7'h7f;
      fs <= 1'b0;
      sd <= 1'b0;
      left_cur <= 24'h000000;
      right_cur <= 24'h000000;
      SAMPLE_TAKEN <= 1'b0;
    end else begin
      SAMPLE_TAKEN <= fall && new_frame;
      if (fall) begin
        d <= next_d;
        fs <= next_fs;
        sd <= next_sd;
        if (new_frame) begin
          left_cur <= LEFT_IN;
          right_cur <= RIGHT_IN;
        end
      end
    end
  end
endmodule
`default_nettype wire

// *** sap_link_props.sv ***
`timescale 1ns/1ns
`default_nettype none
module sap_link_props (
  input wire logic CLK,
  input wire logic RESET_N,
  input wire logic bit_clock,
  input wire logic channel_frame_select,
  input wire logic serial_data
);
  logic sel_q;
  logic bc_q;
  logic armed;
  logic [6:0] rises;
  wire sel_edge = channel_frame_select != sel_q;
  wire bc_rise = bit_clock & ~bc_q;
  // first slot after start may be partial, so slot length is judged once armed
  always_ff @(posedge CLK or negedge RESET_N) begin
    if (!RESET_N) begin
      sel_q <= 1'b0;
      bc_q <= 1'b0;
      armed <= 1'b0;
      rises <= 7'h00;
    end else begin
      sel_q <= channel_frame_select;
      bc_q <= bit_clock;
      armed <= armed | sel_edge;
      rises <= sel_edge ? 7'h00 : rises + {6'h00, bc_rise};
    end
  end
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESET_N);
  a_data_at_rise: assert property ($rose(bit_clock) |-> $stable(serial_data))
    else $error("data moved at bit clock rise");
  a_select_at_rise: assert property ($rose(bit_clock) |-> $stable(channel_frame_select))
    else $error("select moved at bit clock rise");
  a_high_phase: assert property ($rose(bit_clock) |=> bit_clock [*3] ##1 !bit_clock)
    else $error("bit clock high phase wrong");
  a_clock_period: assert property ($rose(bit_clock) |-> ##8 $rose(bit_clock))
    else $error("bit clock period wrong");
  a_select_low_clk: assert property (sel_edge |-> !bit_clock)
    else $error("select changed while bit clock high");
  a_data_low_clk: assert property ($changed(serial_data) |-> !bit_clock)
    else $error("data changed while bit clock high");
  a_slot_bits: assert property (armed && sel_edge |-> rises inside {7'd16, 7'd24, 7'd32})
    else $error("slot length not 16, 24 or 32 bits");
  a_slot_close: assert property (sel_edge |-> ##[128:256] sel_edge)
    else $error("slot not closed in time");
  c_slot16: cover property (armed && sel_edge && rises == 7'd16);
  c_slot24: cover property (armed && sel_edge && rises == 7'd24);
  c_slot32: cover property (armed && sel_edge && rises == 7'd32);
endmodule
`default_nettype wire

// *** tb_serial_audio_port_dc_block.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "sap_regs.svh"
module tb_serial_audio_port_dc_block;
  logic CLK;
  logic RESET_N;
  logic en, hw, sd_n, dcd, wr, rd, valid, irq, pwr, dc_err;
  logic [1:0] fmt;
  logic [5:0] slot;
  logic [4:0] wlen;
  logic [23:0] lin, rin, left, right;
  logic [7:0] addr, wdata, rdata;
  int fail_count;
  int comparisons;
  sap_if link_if ();
  sap_source sap_source_inst (.CLK(CLK), .RESET_N(RESET_N), .LINK(link_if.source),
    .ENABLE(en), .FORMAT(fmt), .SLOT_BITS(slot), .WORD_LEN(wlen), .LEFT_IN(lin),
    .RIGHT_IN(rin), .SAMPLE_TAKEN());
  sap_device #(.HPF_SHIFT(4)) sap_device_inst (.CLK(CLK), .RESET_N(RESET_N),
    .LINK(link_if.device), .HW_MODE(hw), .SHUTDOWN_N(sd_n), .DC_DETECT(dcd), .ADDR(addr),
    .WDATA(wdata), .WR(wr), .RD(rd), .RDATA(rdata), .LEFT(left), .RIGHT(right),
    .SAMPLE_VALID(valid), .IRQ(irq), .POWER_STAGE_EN(pwr), .DC_OUTPUT_ERROR(dc_err));
  sap_link_props sap_link_props_inst (.CLK(CLK), .RESET_N(RESET_N),
    .bit_clock(link_if.bit_clock), .channel_frame_select(link_if.channel_frame_select),
    .serial_data(link_if.serial_data));
  initial begin
    CLK = 1'b0;
    forever #4 CLK = ~CLK;
  end
  task automatic summarize();
    $display("comparisons %0d mismatches %0d", comparisons, fail_count);
    if (fail_count == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string what, input logic [23:0] exp, input logic [23:0] got);
    comparisons++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge CLK);
    #1;
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge CLK);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge CLK);
    wr <= 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e,
    input string what);
    @(posedge CLK);
    addr <= a;
    rd <= 1'b1;
    @(posedge CLK);
    rd <= 1'b0;
    #1;
    check(what, {16'h0000, e}, {16'h0000, rdata & m});
  endtask
  // mid-run reset between setups, the link frozen until configured
  task automatic restart(input logic h, input logic [1:0] f, input logic [5:0] s,
    input logic [4:0] w, input logic [23:0] l, input logic [23:0] r);
    @(posedge CLK);
    RESET_N <= 1'b0;
    en <= 1'b0;
    hw <= h;
    fmt <= f;
    slot <= s;
    wlen <= w;
    lin <= l;
    rin <= r;
    repeat (4) @(posedge CLK);
    RESET_N <= 1'b1;
    idle(8);
  endtask
  task automatic wait_pair();
    int n = 0;
    @(posedge CLK);
    while (valid !== 1'b1 && n < 3000) begin
      @(posedge CLK);
      n++;
    end
    if (n >= 3000) begin
      fail_count++;
      $display("mismatch sample_valid expected 1 seen none");
    end
    #1;
  endtask
  // filter bypassed, so the second pair must equal the source words cut to the word length
  task automatic t_format(input logic [1:0] f, input logic [5:0] s, input logic [4:0] w,
    input logic [23:0] l, input logic [23:0] r, input logic [23:0] el, input logic [23:0] er);
    restart(1'b0, f, s, w, l, r);
    wr_reg(`SAP_CTRL_ADDR, {6'h20, f});
    wr_reg(`SAP_WLEN_ADDR, {3'h0, w});
    @(posedge CLK);
    en <= 1'b1;
    wait_pair();
    wait_pair();
    check("left", el, left);
    check("right", er, right);
    $display("test format %0d slot %0d done", f, s);
  endtask
  task automatic t_hw_filter();
    restart(1'b1, sap_pkg::SAP_FMT_I2S, 6'h18, 5'h18, 24'h100000, 24'hf00000);
    wr_reg(`SAP_CTRL_ADDR, 8'h85);
    rd_chk(`SAP_STATE_ADDR, 8'h0f, 8'h03, "state");
    @(posedge CLK);
    en <= 1'b1;
    wait_pair();
    check("left first", 24'h100000, left);
    wait_pair();
    check("left filtered", 24'h0f0000, left);
    check("right filtered", 24'hf10000, right);
    $display("test hardware filter done");
  endtask
  // filter live in register mode; double speed lowers the shift by one, spare code acts as i2s
  task automatic t_ds();
    restart(1'b0, 2'h3, 6'h10, 5'h10, 24'h100000, 24'hf00000);
    wr_reg(`SAP_CTRL_ADDR, 8'h07);
    rd_chk(`SAP_STATE_ADDR, 8'h0f, 8'h09, "state double speed");
    @(posedge CLK);
    en <= 1'b1;
    wait_pair();
    check("left ds first", 24'h100000, left);
    wait_pair();
    check("left ds filtered", 24'h0e0000, left);
    check("right ds filtered", 24'hf20000, right);
    rd_chk(`SAP_STAT_ADDR, 8'h03, 8'h01, "pair status");
    $display("test double speed done");
  endtask
  task automatic t_dc();
    restart(1'b0, sap_pkg::SAP_FMT_I2S, 6'h20, 5'h18, 24'h0, 24'h0);
    rd_chk(`SAP_CTRL_ADDR, 8'hff, 8'h00, "ctrl");
    rd_chk(`SAP_WLEN_ADDR, 8'h1f, 8'h18, "wlen");
    rd_chk(`SAP_MASK_ADDR, 8'h07, 8'h00, "mask");
    wr_reg(8'h7f, 8'hff);
    rd_chk(8'h7f, 8'hff, 8'h00, "unmapped");
    wr_reg(`SAP_CTRL_ADDR, 8'h08);
    idle(8);
    check("power", 24'h1, {23'h0, pwr});
    @(posedge CLK);
    dcd <= 1'b1;
    idle(8);
    check("fault", 24'h1, {23'h0, dc_err});
    check("power off", 24'h0, {23'h0, pwr});
    check("irq masked", 24'h0, {23'h0, irq});
    rd_chk(`SAP_STAT_ADDR, 8'h04, 8'h04, "status");
    wr_reg(`SAP_MASK_ADDR, 8'h04);
    idle(3);
    check("irq", 24'h1, {23'h0, irq});
    @(posedge CLK);
    dcd <= 1'b0;
    idle(8);
    check("fault held", 24'h1, {23'h0, dc_err});
    @(posedge CLK);
    sd_n <= 1'b0;
    idle(8);
    check("fault cleared", 24'h0, {23'h0, dc_err});
    @(posedge CLK);
    sd_n <= 1'b1;
    wr_reg(`SAP_STAT_ADDR, 8'h04);
    idle(3);
    check("irq cleared", 24'h0, {23'h0, irq});
    $display("test dc fault done");
  endtask
  initial begin
    repeat (60000) @(posedge CLK);
    fail_count++;
    $display("mismatch watchdog expected finish seen timeout");
    summarize();
  end
  initial begin
    fail_count = 0;
    comparisons = 0;
    RESET_N = 1'b0;
    {en, hw, dcd, wr, rd} = 5'h00;
    sd_n = 1'b1;
    {fmt, slot, wlen, lin, rin, addr, wdata} = '0;
    repeat (16) @(posedge CLK);
    t_format(sap_pkg::SAP_FMT_I2S, 6'h20, 5'h18, 24'h5a3c81, 24'ha5c37e,
      24'h5a3c81, 24'ha5c37e);
    t_format(sap_pkg::SAP_FMT_I2S, 6'h10, 5'h10, 24'h8001ff, 24'h7ffe00,
      24'h800100, 24'h7ffe00);
    t_format(sap_pkg::SAP_FMT_LEFT_JUST, 6'h20, 5'h18, 24'hc01234, 24'h3fedcb,
      24'hc01234, 24'h3fedcb);
    t_format(sap_pkg::SAP_FMT_LEFT_JUST, 6'h18, 5'h14, 24'h12345f, 24'h9abcdf,
      24'h123450, 24'h9abcd0);
    t_format(sap_pkg::SAP_FMT_RIGHT_JUST, 6'h20, 5'h18, 24'hc0ffee, 24'h13579b,
      24'hc0ffee, 24'h13579b);
    t_format(sap_pkg::SAP_FMT_RIGHT_JUST, 6'h18, 5'h10, 24'hbeef77, 24'h1234ff,
      24'h00beef, 24'h001234);
    t_hw_filter();
    t_ds();
    t_dc();
    summarize();
  end
endmodule
`default_nettype wire
